// ### logic_equation_bank.v
// Purpose: Bank of cascadable logic equations with delays and latches
// Assumes: cycle_tick_i pulses once per device cycle; inputs synchronous
// Notes:   Select index < NUM_EXT picks an external signal, else an equation
//          output (index - NUM_EXT). Flat config buses, equation e at slice e.
//          Delay counts are in ticks; a zero delay acts as one tick.
`timescale 1ns/1ps
`include "logic_eq_regs.vh"

module logic_equation_bank #(
	parameter NUM_EQ  = `NUM_EQ_DEF,
	parameter NUM_EXT = `NUM_EXT_DEF,
	parameter SEL_W   = 5,
	parameter DLY_W   = `DLY_W_DEF
) (
	input  wire                                 mclk_i,
	input  wire                                 rst_n_i,
	input  wire                                 cycle_tick_i,
	input  wire [NUM_EXT-1:0]                   ext_sig_i,
	input  wire [NUM_EQ*`INPUTS_PER_EQ*SEL_W-1:0] in_sel_i,
	input  wire [NUM_EQ*`INPUTS_PER_EQ-1:0]       in_inv_i,
	input  wire [NUM_EQ*`GATE_W-1:0]              gate_op_i,
	input  wire [NUM_EQ*DLY_W-1:0]                rise_delay_time_i,
	input  wire [NUM_EQ*DLY_W-1:0]                fall_delay_time_i,
	input  wire [NUM_EQ*SEL_W-1:0]                rst_sel_i,
	input  wire [NUM_EQ-1:0]                      rst_inv_i,
	output reg  [NUM_EQ-1:0]                      eq_out_o,
	output reg  [NUM_EQ-1:0]                      eq_latch_o,
	output reg  [NUM_EQ-1:0]                      eq_latch_n_o,
	output reg  [NUM_EQ*`INPUTS_PER_EQ-1:0]       eq_in_state_o
);

	// =================================================================
	// Signal selection
	// Index past the last equation reads as zero
	function sel_sig;
		input [SEL_W-1:0]   sel;
		input [NUM_EXT-1:0] ext;
		input [NUM_EQ-1:0]  eqv;
		integer             k;
		begin
			sel_sig = 1'b0;
			if (sel < NUM_EXT) begin
				for (k = 0; k < NUM_EXT; k = k + 1) begin
					if (sel == k[SEL_W-1:0]) begin
						sel_sig = ext[k];
					end
				end
			end else begin
				for (k = 0; k < NUM_EQ; k = k + 1) begin
					if (sel == k[SEL_W-1:0] + NUM_EXT[SEL_W-1:0]) begin
						sel_sig = eqv[k];
					end
				end
			end
		end
	endfunction

	function gate_eval;
		input [`GATE_W-1:0]        op;
		input [`INPUTS_PER_EQ-1:0] v;
		begin
			case (op)
				`GATE_AND: begin
					gate_eval = &v;
				end
				`GATE_OR: begin
					gate_eval = |v;
				end
				`GATE_NAND: begin
					gate_eval = ~&v;
				end
				`GATE_NOR: begin
					gate_eval = ~|v;
				end
				default: begin
					gate_eval = 1'b0;
				end
			endcase
		end
	endfunction

	// =================================================================
	// Input conditioning: select, then optional inversion per input
	function [`INPUTS_PER_EQ-1:0] cond_vec;
		input [`INPUTS_PER_EQ*SEL_W-1:0] sels;
		input [`INPUTS_PER_EQ-1:0]       inv;
		input [NUM_EXT-1:0]              ext;
		input [NUM_EQ-1:0]               eqv;
		integer                          m;
		begin
			cond_vec = {`INPUTS_PER_EQ{1'b0}};
			for (m = 0; m < `INPUTS_PER_EQ; m = m + 1) begin
				cond_vec[m] = inv[m] ^ sel_sig(sels[m*SEL_W +: SEL_W], ext, eqv);
			end
		end
	endfunction

	// =================================================================
	// Delay timers
	// A high output waits for a fall, a low one for a rise.
	function [DLY_W-1:0] delay_lim;
		input             cur;
		input [DLY_W-1:0] rise;
		input [DLY_W-1:0] fall;
		begin
			if (cur) begin
				delay_lim = fall;
			end else begin
				delay_lim = rise;
			end
		end
	endfunction

	// Zero behaves as one: the change still waits for its tick,
	// so no equation ever switches between ticks.
	function delay_hit;
		input [DLY_W-1:0] cnt;
		input [DLY_W-1:0] lim;
		begin
			delay_hit = (cnt + 1'b1 >= lim) || (lim == {DLY_W{1'b0}});
		end
	endfunction

	// A gate that falls back before the end restarts the count, so short
	// glitches never reach the output.
	function [DLY_W-1:0] dly_cnt_next;
		input             gv;
		input             cur;
		input [DLY_W-1:0] cnt;
		input [DLY_W-1:0] lim;
		begin
			if (gv == cur) begin
				dly_cnt_next = {DLY_W{1'b0}};
			end else if (delay_hit(cnt, lim)) begin
				dly_cnt_next = {DLY_W{1'b0}};
			end else begin
				dly_cnt_next = cnt + 1'b1;
			end
		end
	endfunction

	function dly_out_next;
		input             gv;
		input             cur;
		input [DLY_W-1:0] cnt;
		input [DLY_W-1:0] lim;
		begin
			if (gv != cur && delay_hit(cnt, lim)) begin
				dly_out_next = gv;
			end else begin
				dly_out_next = cur;
			end
		end
	endfunction

	// =================================================================
	// Latch
	// Reset is checked first so a standing reset always wins.
	function latch_next;
		input rst;
		input set;
		input cur;
		begin
			if (rst) begin
				latch_next = 1'b0;
			end else if (set) begin
				latch_next = 1'b1;
			end else begin
				latch_next = cur;
			end
		end
	endfunction

	// =================================================================
	// State
	reg [NUM_EQ*DLY_W-1:0]          cnt_q;
	reg [NUM_EQ*DLY_W-1:0]          cnt_d;
	reg [NUM_EQ-1:0]                out_d;
	reg [NUM_EQ-1:0]                lat_d;
	reg [NUM_EQ*`INPUTS_PER_EQ-1:0] ins_d;
	reg [NUM_EQ-1:0]                view;
	reg [`INPUTS_PER_EQ-1:0]        cond;
	reg                             g;
	reg                             rstv;
	reg [DLY_W-1:0]                 c;
	reg [DLY_W-1:0]                 lim;
	integer                         e;

	// Per-equation slices of the flat configuration buses
	reg [`INPUTS_PER_EQ*SEL_W-1:0]  sel_e;
	reg [`INPUTS_PER_EQ-1:0]        inv_e;
	reg [`GATE_W-1:0]               op_e;
	reg [DLY_W-1:0]                 rise_e;
	reg [DLY_W-1:0]                 fall_e;
	reg [SEL_W-1:0]                 rsel_e;
	reg                             rinv_e;

	// =================================================================
	// One evaluation pass, ascending index. view starts as last pass's
	// outputs and each result is written back before the next equation,
	// so forward cascades settle in one pass and backward ones lag by one.
	always @* begin
		view   = eq_out_o;
		cnt_d  = cnt_q;
		lat_d  = eq_latch_o;
		ins_d  = eq_in_state_o;
		out_d  = eq_out_o;
		cond   = {`INPUTS_PER_EQ{1'b0}};
		g      = 1'b0;
		rstv   = 1'b0;
		c      = {DLY_W{1'b0}};
		lim    = {DLY_W{1'b0}};
		sel_e  = {`INPUTS_PER_EQ*SEL_W{1'b0}};
		inv_e  = {`INPUTS_PER_EQ{1'b0}};
		op_e   = `GATE_AND;
		rise_e = {DLY_W{1'b0}};
		fall_e = {DLY_W{1'b0}};
		rsel_e = {SEL_W{1'b0}};
		rinv_e = 1'b0;
		for (e = 0; e < NUM_EQ; e = e + 1) begin
			sel_e  = in_sel_i[e*`INPUTS_PER_EQ*SEL_W +: `INPUTS_PER_EQ*SEL_W];
			inv_e  = in_inv_i[e*`INPUTS_PER_EQ +: `INPUTS_PER_EQ];
			op_e   = gate_op_i[e*`GATE_W +: `GATE_W];
			rise_e = rise_delay_time_i[e*DLY_W +: DLY_W];
			fall_e = fall_delay_time_i[e*DLY_W +: DLY_W];
			rsel_e = rst_sel_i[e*SEL_W +: SEL_W];
			rinv_e = rst_inv_i[e];

			cond = cond_vec(sel_e, inv_e, ext_sig_i, view);
			g    = gate_eval(op_e, cond);
			c    = cnt_q[e*DLY_W +: DLY_W];
			lim  = delay_lim(eq_out_o[e], rise_e, fall_e);

			// Timer
			out_d[e]                = dly_out_next(g, eq_out_o[e], c, lim);
			cnt_d[e*DLY_W +: DLY_W] = dly_cnt_next(g, eq_out_o[e], c, lim);
			// Later equations must see this result within the same pass
			view[e] = out_d[e];

			// Latch, seeing this pass's outputs up to and including this one
			rstv     = rinv_e ^ sel_sig(rsel_e, ext_sig_i, view);
			lat_d[e] = latch_next(rstv, out_d[e], eq_latch_o[e]);
			ins_d[e*`INPUTS_PER_EQ +: `INPUTS_PER_EQ] = cond;
		end
	end

	// =================================================================
	// Commit once per device cycle
	// Every register below moves only on a tick; between ticks the
	// bank is frozen so outputs stand for a whole pass.
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= {NUM_EQ*DLY_W{1'b0}};
		end else if (cycle_tick_i) begin
			cnt_q <= cnt_d;
		end
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eq_out_o <= {NUM_EQ{1'b0}};
		end else if (cycle_tick_i) begin
			eq_out_o <= out_d;
		end
	end

	// Complement is its own flop so it never glitches against the latch
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eq_latch_o   <= {NUM_EQ{1'b0}};
			eq_latch_n_o <= {NUM_EQ{1'b1}};
		end else if (cycle_tick_i) begin
			eq_latch_o   <= lat_d;
			eq_latch_n_o <= ~lat_d;
		end
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eq_in_state_o <= {NUM_EQ*`INPUTS_PER_EQ{1'b0}};
		end else if (cycle_tick_i) begin
			eq_in_state_o <= ins_d;
		end
	end

endmodule

// ### logic_eq_regs.vh
// Purpose: Constants for the programmable logic equation bank
// Assumes: One evaluation pass per device cycle tick
// Notes:   Gate operator encodings and parameter defaults
`ifndef LOGIC_EQ_REGS_VH
`define LOGIC_EQ_REGS_VH

// =====================================================================
// Gate operators
`define GATE_W        2
`define GATE_AND      2'h0
`define GATE_OR       2'h1
`define GATE_NAND     2'h2
`define GATE_NOR      2'h3

// =====================================================================
// Defaults
`define NUM_EQ_DEF    8
`define NUM_EXT_DEF   16
`define DLY_W_DEF     16
`define INPUTS_PER_EQ 4

`endif

// ### leb_chk.sv
// Purpose: Port assertions for logic_equation_bank
// Assumes: Equation 0 selects below NUM_EXT for its first input and its reset
// Notes: Bound from tb
`timescale 1ns/1ps
module leb_chk #(parameter NUM_EQ = 4, NUM_EXT = 16, SEL_W = 5) (
	input wire                      mclk_i,
	input wire                      rst_n_i,
	input wire                      cycle_tick_i,
	input wire [NUM_EXT-1:0]        ext_sig_i,
	input wire [NUM_EQ*4*SEL_W-1:0] in_sel_i,
	input wire [NUM_EQ*4-1:0]       in_inv_i,
	input wire [NUM_EQ*SEL_W-1:0]   rst_sel_i,
	input wire [NUM_EQ-1:0]         rst_inv_i,
	input wire [NUM_EQ-1:0]         eq_out_o,
	input wire [NUM_EQ-1:0]         eq_latch_o,
	input wire [NUM_EQ-1:0]         eq_latch_n_o,
	input wire [NUM_EQ*4-1:0]       eq_in_state_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (!rst_n_i);
wire t  = cycle_tick_i;
wire r0 = ext_sig_i[rst_sel_i[3:0]] ^ rst_inv_i[0];
wire x0 = ext_sig_i[in_sel_i[3:0]] ^ in_inv_i[0];
latch_cmp_a: assert property (eq_latch_n_o == ~eq_latch_o) else $error("latch complement");
out_idle_a: assert property (!t |=> $stable(eq_out_o)) else $error("out moved");
latch_idle_a: assert property (!t |=> $stable(eq_latch_o)) else $error("latch moved");
state_idle_a: assert property (!t |=> $stable(eq_in_state_o)) else $error("state moved");
in_cond_a: assert property (t && !in_sel_i[4] |=> eq_in_state_o[0] == $past(x0)) else $error("input");
latch_set_a: assert property ($rose(eq_latch_o[0]) |-> eq_out_o[0]) else $error("latch set");
rst_dom_a: assert property (t && !rst_sel_i[4] && r0 |=> !eq_latch_o[0]) else $error("reset");
latch_hold_a: assert property (t && !rst_sel_i[4] && !r0 && eq_latch_o[0] |=> eq_latch_o[0]) else $error("hold");
endmodule

// ### sig_src.sv
// Purpose: Source of external signals and device cycle ticks
// Assumes: One pass every four clocks
// Notes: Signals follow the request one clock later
`timescale 1ns/1ps
module sig_src (
	input  wire        mclk_i,
	input  wire        rst_n_i,
	input  wire [15:0] want_i,
	output reg         tick_o,
	output reg  [15:0] sig_o
);
reg [1:0] cnt_q;
always @(posedge mclk_i or negedge rst_n_i) begin
	if (!rst_n_i) {cnt_q, tick_o, sig_o} <= 19'h0;
	else begin
		cnt_q <= cnt_q + 2'h1;
		tick_o <= (cnt_q == 2'h2);
		sig_o <= want_i;
	end
end
endmodule

// ### tb.sv
// Purpose: Self-checking bench for logic_equation_bank
// Assumes: Inputs change only between passes
// Notes: Short delays on equation 3 keep the run brief
`timescale 1ns/1ps
module tb;
reg mclk_i = 1'b0;
reg rst_n_i = 1'b0;
reg [15:0] want = 16'h0000;
reg [7:0] gop = 8'h14;
reg [3:0] rinv = 4'h0;
wire tick;
wire [15:0] sig, st;
wire [3:0] out, lat, lat_n;
integer err_total = 0, comparisons = 0, cyc = 0;
always #12.5 mclk_i = ~mclk_i;
always @(posedge mclk_i) begin
	cyc = cyc + 1;
	if (cyc == 2000) begin err_total = err_total + 1; end_sim; end
end
sig_src u_sig_src (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .want_i(want), .tick_o(tick), .sig_o(sig));
logic_equation_bank #(.NUM_EQ(4), .DLY_W(4)) u_logic_equation_bank (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.cycle_tick_i(tick), .ext_sig_i(sig), .in_sel_i(80'hfffe6_fffe4_ffe50_18820), .in_inv_i(16'he008),
	.gate_op_i(gop), .rise_delay_time_i(16'h3000), .fall_delay_time_i(16'h2000), .rst_sel_i(20'hfffe5),
	.rst_inv_i(rinv), .eq_out_o(out), .eq_latch_o(lat), .eq_latch_n_o(lat_n), .eq_in_state_o(st));
task chk(input string n, input [7:0] s, input [7:0] e);
	begin
		comparisons = comparisons + 1;
		if (s !== e) begin err_total = err_total + 1; $display("[ERR] %s exp %h seen %h", n, e, s); end
	end
endtask
task go(input [15:0] v, input integer n);
	begin @(posedge mclk_i) want <= v; repeat (n) @(posedge mclk_i iff tick); #1; end
endtask
task t_casc;
	begin
		go(16'h0007, 1); chk("casc up", out, 8'h03);
		chk("in state", st[3:0], 8'h0f);
		go(16'h0010, 1); chk("casc down a", out, 8'h04);
		go(16'h0010, 1); chk("casc down b", out, 8'h06);
	end
endtask
task t_latch;
	begin
		go(16'h0027, 1); chk("rst wins", lat[0], 8'h00);
		chk("latch inv", lat_n[0], 8'h01);
		go(16'h0007, 1); chk("latch set", lat[0], 8'h01);
		go(16'h0000, 1); chk("latch hold", lat[0], 8'h01);
		go(16'h0020, 1); chk("latch rst", lat[0], 8'h00);
	end
endtask
task t_delay;
	begin
		go(16'h0040, 2); chk("rise early", out[3], 8'h00);
		go(16'h0040, 1); chk("rise done", out[3], 8'h01);
		go(16'h0000, 1); chk("fall early", out[3], 8'h01);
		go(16'h0040, 1); go(16'h0000, 1); chk("fall restart", out[3], 8'h01);
		go(16'h0000, 1); chk("fall done", out[3], 8'h00);
	end
endtask
task t_gate;
	begin
		@(posedge mclk_i) gop <= 8'h36;
		go(16'h0007, 1); chk("nand nor", out, 8'h04);
		go(16'h0007, 1); chk("nor casc", out, 8'h06);
		@(posedge mclk_i) rinv <= 4'h1;
		go(16'h0003, 1); chk("nand hi", out, 8'h07);
		chk("rst inv", lat[0], 8'h00);
		@(posedge mclk_i) rinv <= 4'h0;
		go(16'h0003, 1); chk("rst plain", lat[0], 8'h01);
	end
endtask
task end_sim;
	begin
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	end
endtask
initial begin
	repeat (16) @(posedge mclk_i);
	rst_n_i <= 1'b1;
	@(posedge mclk_i iff tick); #1;
	chk("idle", {lat_n, out}, 8'hf0);
	t_casc; t_latch; t_delay; t_gate; end_sim;
end
endmodule
bind logic_equation_bank leb_chk #(.NUM_EQ(NUM_EQ), .NUM_EXT(NUM_EXT), .SEL_W(SEL_W)) u_leb_chk (.mclk_i(mclk_i),
	.rst_n_i(rst_n_i), .cycle_tick_i(cycle_tick_i), .ext_sig_i(ext_sig_i), .in_sel_i(in_sel_i), .in_inv_i(in_inv_i),
	.rst_sel_i(rst_sel_i), .rst_inv_i(rst_inv_i), .eq_out_o(eq_out_o), .eq_latch_o(eq_latch_o),
	.eq_latch_n_o(eq_latch_n_o), .eq_in_state_o(eq_in_state_o));
